// >>> hw/sfm_pkg.sv
// Package with register map, field layout and timing constants of the serial mode block.
package sfm_pkg;
    // ==========================================================
    // Register map
    localparam logic [15:0] ASYNC_FRAME_MODE_ADDR = 16'hFF70;
    localparam logic [15:0] SYNC_SERIAL_MODE_ADDR = 16'hFF72;
    localparam logic [7:0] MODE_RESET_VALUE = 8'h00;
    // Writable bits; reserved bits are kept at zero and read back as zero.
    localparam logic [7:0] SYNC_WRITE_MASK = 8'hCF;
    localparam logic [7:0] ASYNC_WRITE_MASK = 8'hFC;
    // ==========================================================
    // Field positions of sync_serial_mode
    localparam int SYNC_ENABLE_POS = 7;
    localparam int SLAVE_SELECT_USE_POS = 6;
    localparam int DATA_PHASE_POS = 3;
    localparam int FIRST_BIT_ORDER_POS = 2;
    localparam int SYNC_CLOCK_SOURCE_POS = 1;
    localparam int CLOCK_POLARITY_POS = 0;
    // ==========================================================
    // Field positions of async_frame_mode
    localparam int TRANSMIT_ENABLE_POS = 7;
    localparam int RECEIVE_ENABLE_POS = 6;
    localparam int PARITY_SELECT_HIGH_POS = 5;
    localparam int PARITY_SELECT_LOW_POS = 4;
    localparam int CHAR_LENGTH_POS = 3;
    localparam int STOP_LENGTH_POS = 2;
    // ==========================================================
    // Parity codes
    localparam logic [1:0] PARITY_NONE = 2'h0;
    localparam logic [1:0] PARITY_ZERO = 2'h1;
    localparam logic [1:0] PARITY_ODD = 2'h2;
    localparam logic [1:0] PARITY_EVEN = 2'h3;
    // ==========================================================
    // Timing
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0] MID_BIT_TICK = 4'h7;
    localparam logic [2:0] LAST_BIT_EIGHT = 3'h7;
    localparam logic [2:0] LAST_BIT_SEVEN = 3'h6;
    localparam logic [4:0] SYNC_LAST_EDGE = 5'h0F;
    localparam int CLOCK_HZ = 250_000_000;
    localparam int OVERSAMPLE = 16;
    localparam int MIDI_BPS = 31250;
    localparam logic [15:0] MIDI_DIVISOR = 16'(CLOCK_HZ / (MIDI_BPS * OVERSAMPLE));
    // ==========================================================
    // Frame phases, Gray coded from idle through parity to stop
    typedef enum logic [2:0] {
        PH_IDLE = 3'h0,
        PH_START = 3'h1,
        PH_DATA = 3'h3,
        PH_PARITY = 3'h2,
        PH_STOP = 3'h6
    } sfm_phase_t;
endpackage : sfm_pkg

// >>> hw/sfm_bit_clock.sv
// Oversampling tick source: internal divider or the external asynchronous clock pin.
`timescale 1ns/1ps
module sfm_bit_clock #(
    parameter int DIV_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic useExtClock,
    input wire logic [DIV_WIDTH-1:0] divisor,
    input wire logic asyncExtClockPin,
    output logic tick16
);
    logic [DIV_WIDTH-1:0] divCnt_reg;
    logic extPrev_reg;
    logic intTick;

    // ==========================================================
    // Internal divider; a divisor of zero is treated as one.
    assign intTick = (divCnt_reg + DIV_WIDTH'(1)) >= divisor;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt_reg <= '0;
        end else if (useExtClock || intTick) begin
            divCnt_reg <= '0; // R16
        end else begin
            divCnt_reg <= divCnt_reg + DIV_WIDTH'(1);
        end
    end

    // ==========================================================
    // Each rising edge on the pin is one sixteenth of a bit, so rate is pin clock over 16.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            extPrev_reg <= 1'b0;
        end else begin
            extPrev_reg <= asyncExtClockPin;
        end
    end

    assign tick16 = useExtClock ? (asyncExtClockPin && !extPrev_reg) : intTick; // R17 R19
endmodule : sfm_bit_clock

// >>> hw/sfm_serial_mode.sv
// Mode registers, UART frame engine and 3-wire synchronous engine of the serial port.
`timescale 1ns/1ps
// Overview of operation
// R1: sync_serial_mode register read/write at its address, cleared to zero by reset.
// R2: async_frame_mode register read/write at its address, cleared to zero by reset.
// R3: 3-wire synchronous operation runs only while sync_enable_bit is one.
// R4: Software writes sync_serial_mode with zeros before using UART mode.
// R5: Slave select off: always enabled; on: low pin enables, high pin disables.
// R6: Data changes on falling edge if phase 0, rising if 1; order MSB/LSB.
// R7: Serial clock from pin when source bit 0, from baud generator when 1.
// R8: Polarity 0 idles clock high; polarity 1 idles clock low.
// R9: Software writes zero to bits 4 and 5 of sync_serial_mode.
// R10: UART moves one byte per start bit, independent transmit and receive.
// R11: Parity field: none, forced zero, odd, even.
// R12: Forced zero parity never checked and never flags an error.
// R13: Character length 7 or 8 bits; transmit stop length 1 or 2.
// R14: Software writes zero to bits 0 and 1 of async_frame_mode.
// R15: Software stops transfers before changing the operating mode.
// R16: Baud generator can produce 31.25 kbps.
// R17: UART rate can be derived by dividing the external clock pin.
// R18: Receiver checks only one stop bit.
// R19: External clock rate is the pin frequency divided by 16.
// R20: Frame is start bit, character bits, optional parity, one or two stops.
// R21: Receiver detects falling start edge and samples mid-bit at sixteen times.
module sfm_serial_mode #(
    parameter int DIV_WIDTH = 16,
    parameter logic [DIV_WIDTH-1:0] BAUD_DIVISOR = DIV_WIDTH'(sfm_pkg::MIDI_DIVISOR)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic useExtBaudClock,
    input wire logic asyncExtClockPin,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic [7:0] rxData,
    output logic rxValid,
    output logic parityError,
    output logic framingError,
    input wire logic rxdPin,
    output logic txdPin,
    output logic txdOe,
    input wire logic syncSerialClockPin,
    output logic syncSerialClockOut,
    output logic syncSerialClockOe,
    input wire logic slaveSelectPin,
    output logic sharedPortPinIsPort
);
    logic [7:0] syncMode_reg;
    logic [7:0] asyncMode_reg;
    logic syncEnable, slaveSelectUse, dataPhase, firstBitOrder, syncClockSource, clockPolarity;
    logic transmitEnable, receiveEnable, charLength, stopLength;
    logic [1:0] paritySelect;
    logic commEnable, tick16;
    logic [2:0] lastBit;
    // ==========================================================
    // Register file
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncMode_reg <= sfm_pkg::MODE_RESET_VALUE;
            asyncMode_reg <= sfm_pkg::MODE_RESET_VALUE;
        end else if (regWrEn) begin
            if (regAddr == sfm_pkg::SYNC_SERIAL_MODE_ADDR) begin
                syncMode_reg <= regWrData & sfm_pkg::SYNC_WRITE_MASK; // R1 R9
            end
            if (regAddr == sfm_pkg::ASYNC_FRAME_MODE_ADDR) begin
                asyncMode_reg <= regWrData & sfm_pkg::ASYNC_WRITE_MASK; // R2 R14
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            unique case (regAddr)
                sfm_pkg::SYNC_SERIAL_MODE_ADDR: regRdData <= syncMode_reg; // R1
                sfm_pkg::ASYNC_FRAME_MODE_ADDR: regRdData <= asyncMode_reg; // R2
                default: regRdData <= 8'h00;
            endcase
        end
    end

    assign syncEnable = syncMode_reg[sfm_pkg::SYNC_ENABLE_POS];
    assign slaveSelectUse = syncMode_reg[sfm_pkg::SLAVE_SELECT_USE_POS];
    assign dataPhase = syncMode_reg[sfm_pkg::DATA_PHASE_POS];
    assign firstBitOrder = syncMode_reg[sfm_pkg::FIRST_BIT_ORDER_POS];
    assign syncClockSource = syncMode_reg[sfm_pkg::SYNC_CLOCK_SOURCE_POS];
    assign clockPolarity = syncMode_reg[sfm_pkg::CLOCK_POLARITY_POS];
    assign transmitEnable = asyncMode_reg[sfm_pkg::TRANSMIT_ENABLE_POS];
    assign receiveEnable = asyncMode_reg[sfm_pkg::RECEIVE_ENABLE_POS];
    assign paritySelect = {asyncMode_reg[sfm_pkg::PARITY_SELECT_HIGH_POS],
                           asyncMode_reg[sfm_pkg::PARITY_SELECT_LOW_POS]};
    assign charLength = asyncMode_reg[sfm_pkg::CHAR_LENGTH_POS];
    assign stopLength = asyncMode_reg[sfm_pkg::STOP_LENGTH_POS];
    assign lastBit = charLength ? sfm_pkg::LAST_BIT_EIGHT : sfm_pkg::LAST_BIT_SEVEN; // R13
    assign commEnable = !slaveSelectUse || !slaveSelectPin; // R5
    assign sharedPortPinIsPort = !slaveSelectUse; // R5

    sfm_bit_clock #(.DIV_WIDTH(DIV_WIDTH)) bitClock (
        .clk(clk),
        .rst(rst),
        .useExtClock(useExtBaudClock),
        .divisor(BAUD_DIVISOR),
        .asyncExtClockPin(asyncExtClockPin),
        .tick16(tick16)
    );
    // ==========================================================
    // UART transmitter
    sfm_pkg::sfm_phase_t txPhase_reg;
    logic [3:0] txTick_reg;
    logic [2:0] txBit_reg;
    logic [7:0] txShift_reg;
    logic txParity_reg, txStop2_reg, uartTxd_reg;
    logic uartStart, txBitEnd, txParityBit;
    logic [7:0] txMasked;

    assign uartStart = txValid && txReady && !syncEnable;
    assign txBitEnd = tick16 && (txTick_reg == sfm_pkg::OVERSAMPLE_LAST);
    assign txMasked = charLength ? txData : {1'b0, txData[6:0]};
    assign txParityBit = (paritySelect == sfm_pkg::PARITY_ODD) ? ~^txMasked :
                         (paritySelect == sfm_pkg::PARITY_EVEN) ? ^txMasked : 1'b0; // R11

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txPhase_reg <= sfm_pkg::PH_IDLE;
            txTick_reg <= 4'h0;
            txBit_reg <= 3'h0;
            txShift_reg <= 8'h00;
            txParity_reg <= 1'b0;
            txStop2_reg <= 1'b0;
            uartTxd_reg <= 1'b1;
        end else begin
            if (tick16 && txPhase_reg != sfm_pkg::PH_IDLE) begin
                txTick_reg <= txTick_reg + 4'h1;
            end
            unique case (txPhase_reg)
                sfm_pkg::PH_IDLE: begin
                    if (uartStart) begin
                        txPhase_reg <= sfm_pkg::PH_START;
                        txShift_reg <= txMasked;
                        txParity_reg <= txParityBit;
                        txStop2_reg <= stopLength; // R13
                        txTick_reg <= 4'h0;
                        uartTxd_reg <= 1'b0; // R20
                    end
                end
                sfm_pkg::PH_START: begin
                    if (txBitEnd) begin
                        txPhase_reg <= sfm_pkg::PH_DATA;
                        txBit_reg <= 3'h0;
                        uartTxd_reg <= txShift_reg[0];
                        txShift_reg <= {1'b0, txShift_reg[7:1]};
                    end
                end
                sfm_pkg::PH_DATA: begin
                    if (txBitEnd) begin
                        txBit_reg <= txBit_reg + 3'h1;
                        uartTxd_reg <= txShift_reg[0];
                        txShift_reg <= {1'b0, txShift_reg[7:1]};
                        if (txBit_reg == lastBit) begin
                            if (paritySelect != sfm_pkg::PARITY_NONE) begin
                                txPhase_reg <= sfm_pkg::PH_PARITY;
                                uartTxd_reg <= txParity_reg; // R11
                            end else begin
                                txPhase_reg <= sfm_pkg::PH_STOP;
                                uartTxd_reg <= 1'b1;
                            end
                        end
                    end
                end
                sfm_pkg::PH_PARITY: begin
                    if (txBitEnd) begin
                        txPhase_reg <= sfm_pkg::PH_STOP;
                        uartTxd_reg <= 1'b1;
                    end
                end
                sfm_pkg::PH_STOP: begin
                    if (txBitEnd) begin
                        txStop2_reg <= 1'b0;
                        if (!txStop2_reg) begin
                            txPhase_reg <= sfm_pkg::PH_IDLE; // R20
                        end
                    end
                end
                default: txPhase_reg <= sfm_pkg::PH_IDLE;
            endcase
        end
    end
    // ==========================================================
    // UART receiver; only the first stop bit is checked, so a second one is free idle time.
    sfm_pkg::sfm_phase_t rxPhase_reg;
    logic [3:0] rxTick_reg;
    logic [2:0] rxBit_reg;
    logic [7:0] rxShift_reg;
    logic rxdPrev_reg, rxParity_reg, uartDone, rxSample;
    logic rxParityBad;

    assign rxSample = tick16 && (rxTick_reg == sfm_pkg::OVERSAMPLE_LAST);
    assign uartDone = rxSample && rxPhase_reg == sfm_pkg::PH_STOP;
    assign rxParityBad = (paritySelect == sfm_pkg::PARITY_ODD) ? (~^{rxShift_reg, rxParity_reg}) :
                         (paritySelect == sfm_pkg::PARITY_EVEN) ? (^{rxShift_reg, rxParity_reg}) :
                         1'b0; // R12

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxdPrev_reg <= 1'b1;
        end else begin
            rxdPrev_reg <= rxdPin;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxPhase_reg <= sfm_pkg::PH_IDLE;
            rxTick_reg <= 4'h0;
            rxBit_reg <= 3'h0;
            rxShift_reg <= 8'h00;
            rxParity_reg <= 1'b0;
        end else begin
            if (tick16 && rxPhase_reg != sfm_pkg::PH_IDLE) begin
                rxTick_reg <= rxTick_reg + 4'h1;
            end
            unique case (rxPhase_reg)
                sfm_pkg::PH_IDLE: begin
                    if (receiveEnable && !syncEnable && rxdPrev_reg && !rxdPin) begin
                        rxPhase_reg <= sfm_pkg::PH_START; // R21
                        rxTick_reg <= 4'h0;
                    end
                end
                sfm_pkg::PH_START: begin
                    if (tick16 && rxTick_reg == sfm_pkg::MID_BIT_TICK) begin
                        rxTick_reg <= 4'h0; // R21
                        rxBit_reg <= 3'h0;
                        rxShift_reg <= 8'h00;
                        rxPhase_reg <= rxdPin ? sfm_pkg::PH_IDLE : sfm_pkg::PH_DATA;
                    end
                end
                sfm_pkg::PH_DATA: begin
                    if (rxSample) begin
                        rxShift_reg[rxBit_reg] <= rxdPin; // R10
                        rxBit_reg <= rxBit_reg + 3'h1;
                        if (rxBit_reg == lastBit) begin
                            rxPhase_reg <= (paritySelect != sfm_pkg::PARITY_NONE) ?
                                           sfm_pkg::PH_PARITY : sfm_pkg::PH_STOP;
                        end
                    end
                end
                sfm_pkg::PH_PARITY: begin
                    if (rxSample) begin
                        rxParity_reg <= rxdPin;
                        rxPhase_reg <= sfm_pkg::PH_STOP;
                    end
                end
                sfm_pkg::PH_STOP: begin
                    if (rxSample) begin
                        rxPhase_reg <= sfm_pkg::PH_IDLE; // R18
                    end
                end
                default: rxPhase_reg <= sfm_pkg::PH_IDLE;
            endcase
        end
    end
    // ==========================================================
    // 3-wire synchronous engine
    logic syncBusy_reg, sckGen_reg, sckPrev_reg, syncBit_reg;
    logic [4:0] syncEdge_reg;
    logic [7:0] syncShift_reg, syncRx_reg;
    logic sckLine, sckRise, sckFall, shiftEdge, sampleEdge, anyEdge, syncStart, syncDone;

    assign sckLine = syncClockSource ? sckGen_reg : syncSerialClockPin; // R7
    assign sckRise = sckLine && !sckPrev_reg;
    assign sckFall = !sckLine && sckPrev_reg;
    assign anyEdge = syncBusy_reg && commEnable && (sckRise || sckFall);
    assign shiftEdge = anyEdge && (dataPhase ? sckRise : sckFall); // R6
    assign sampleEdge = anyEdge && (dataPhase ? sckFall : sckRise);
    assign syncStart = txValid && txReady && syncEnable;
    assign syncDone = anyEdge && syncEdge_reg == sfm_pkg::SYNC_LAST_EDGE;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sckPrev_reg <= 1'b1;
            sckGen_reg <= 1'b1;
        end else begin
            sckPrev_reg <= sckLine;
            if (!syncBusy_reg) begin
                sckGen_reg <= ~clockPolarity; // R8
            end else if (tick16 && syncClockSource && commEnable) begin
                sckGen_reg <= ~sckGen_reg; // R7
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncBusy_reg <= 1'b0;
            syncEdge_reg <= 5'h00;
            syncShift_reg <= 8'h00;
            syncRx_reg <= 8'h00;
            syncBit_reg <= 1'b0;
        end else if (!syncEnable) begin
            syncBusy_reg <= 1'b0; // R3
            syncEdge_reg <= 5'h00;
        end else if (syncStart) begin
            syncBusy_reg <= 1'b1;
            syncEdge_reg <= 5'h00;
            syncShift_reg <= txData;
            syncBit_reg <= firstBitOrder ? txData[0] : txData[7]; // R6
        end else if (anyEdge) begin
            syncEdge_reg <= syncEdge_reg + 5'h01;
            if (syncDone) begin
                syncBusy_reg <= 1'b0;
            end
            if (sampleEdge) begin
                syncRx_reg <= firstBitOrder ? {rxdPin, syncRx_reg[7:1]} :
                                              {syncRx_reg[6:0], rxdPin};
            end
            // The first edge never shifts: the first bit is already on the line.
            if (shiftEdge && syncEdge_reg != 5'h00) begin
                syncShift_reg <= firstBitOrder ? {1'b0, syncShift_reg[7:1]} :
                                                 {syncShift_reg[6:0], 1'b0};
                syncBit_reg <= firstBitOrder ? syncShift_reg[1] : syncShift_reg[6]; // R6
            end
        end
    end
    // ==========================================================
    // Results and pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxData <= 8'h00;
            rxValid <= 1'b0;
            parityError <= 1'b0;
            framingError <= 1'b0;
        end else begin
            rxValid <= uartDone || syncDone;
            parityError <= uartDone && rxParityBad; // R12
            framingError <= uartDone && !rxdPin; // R18
            if (uartDone) begin
                rxData <= rxShift_reg;
            end else if (syncDone && sampleEdge) begin
                rxData <= firstBitOrder ? {rxdPin, syncRx_reg[7:1]} : {syncRx_reg[6:0], rxdPin};
            end else if (syncDone) begin
                // When the last edge is a shift edge all eight bits are already captured.
                rxData <= syncRx_reg; // R6
            end
        end
    end

    assign txReady = syncEnable ? (!syncBusy_reg && commEnable) :
                     (transmitEnable && txPhase_reg == sfm_pkg::PH_IDLE); // R10
    assign txdPin = syncEnable ? syncBit_reg : uartTxd_reg;
    assign txdOe = syncEnable ? commEnable : transmitEnable;
    assign syncSerialClockOut = sckGen_reg;
    assign syncSerialClockOe = syncEnable && syncClockSource; // R7
    // ==========================================================
    // Checks
    AST_SYNC_WRITE: assert property (@(posedge clk) disable iff (rst) // R1
        regWrEn && regAddr == sfm_pkg::SYNC_SERIAL_MODE_ADDR |=>
        syncMode_reg == ($past(regWrData) & sfm_pkg::SYNC_WRITE_MASK))
        else $error("sync mode register write lost");
    AST_ASYNC_READ: assert property (@(posedge clk) disable iff (rst) // R2
        regRdEn && regAddr == sfm_pkg::ASYNC_FRAME_MODE_ADDR |=> regRdData == $past(asyncMode_reg))
        else $error("async mode register read wrong");
    AST_SYNC_OFF: assert property (@(posedge clk) disable iff (rst) // R3
        !syncEnable |=> !syncBusy_reg)
        else $error("sync transfer while disabled");
    AST_SS_BLOCK: assert property (@(posedge clk) disable iff (rst) // R5
        syncEnable && slaveSelectUse && slaveSelectPin |-> !txReady && !anyEdge)
        else $error("transfer while slave select high");
    AST_SCK_IDLE: assert property (@(posedge clk) disable iff (rst) // R8
        !syncBusy_reg ##1 !syncBusy_reg |-> sckGen_reg == ~$past(clockPolarity))
        else $error("serial clock not at idle level");
    AST_TX_START: assert property (@(posedge clk) disable iff (rst) // R20
        uartStart |=> !txdPin ##1 txPhase_reg == sfm_pkg::PH_START)
        else $error("start bit not low");
    AST_ZERO_PARITY: assert property (@(posedge clk) disable iff (rst) // R12
        paritySelect == sfm_pkg::PARITY_ZERO && uartDone |=> !parityError)
        else $error("parity error in forced zero mode");
    AST_STOP_END: assert property (@(posedge clk) disable iff (rst) // R13
        txPhase_reg == sfm_pkg::PH_STOP && txBitEnd && !txStop2_reg |=>
        txPhase_reg == sfm_pkg::PH_IDLE && txdPin == 1'b1)
        else $error("stop bit did not end frame");
    COV_UART_TX: cover property (@(posedge clk) disable iff (rst) uartStart);
    COV_UART_RX: cover property (@(posedge clk) disable iff (rst) uartDone);
    COV_SYNC_DONE: cover property (@(posedge clk) disable iff (rst) syncDone);
endmodule : sfm_serial_mode

// >>> testbench/sfm_remote_loop.sv
// Remote serial device model that echoes the transmit line back to the receive line.
`timescale 1ns/1ps
module sfm_remote_loop (
    input wire logic txdPin,
    input wire logic txdOe,
    output logic rxdPin
);
    // The line has a pull-up, so a released transmitter reads as idle high.
    assign rxdPin = txdOe ? txdPin : 1'b1;
endmodule : sfm_remote_loop

// >>> testbench/sfm_serial_mode_tb_top.sv
// Self-checking bench for the serial mode block with a loopback remote device.
`timescale 1ns/1ps
module sfm_serial_mode_tb_top;
    logic clk, rst, regWrEn, regRdEn, txValid, txReady, rxValid, parityError, framingError;
    logic rxdPin, txdPin, txdOe, sckOut, sckOe, slaveSelectPin, isPort, useExtBaud;
    logic extClk = 1'b0;
    logic [15:0] regAddr;
    logic [7:0] regWrData, regRdData, txData, rxData, rdVal;
    int num_errors = 0;
    int num_checks = 0;
    // ==========================================================
    // Design and remote device
    sfm_serial_mode #(.BAUD_DIVISOR(16'h0002)) dut (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .useExtBaudClock(useExtBaud), .asyncExtClockPin(extClk), .txData(txData),
        .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
        .parityError(parityError),
        .framingError(framingError), .rxdPin(rxdPin), .txdPin(txdPin), .txdOe(txdOe),
        .syncSerialClockPin(1'b0), .syncSerialClockOut(sckOut), .syncSerialClockOe(sckOe),
        .slaveSelectPin(slaveSelectPin), .sharedPortPinIsPort(isPort));
    sfm_remote_loop remote (.txdPin(txdPin), .txdOe(txdOe), .rxdPin(rxdPin));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // The external baud clock runs free; it only matters while it is selected.
    always @(posedge clk) #1 extClk = ~extClk;
    // ==========================================================
    // Shared tasks
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check8
    task automatic check1(input logic got, input logic exp, input string msg);
        check8({7'h00, got}, {7'h00, exp}, msg);
    endtask : check1
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clk) #1;
        regWrEn = 1'b0;
        // The strobe rests one cycle so that back-to-back calls never merge.
        @(posedge clk) #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clk) #1;
        regRdEn = 1'b0;
        d = regRdData;
        @(posedge clk) #1;
    endtask : rd
    task automatic wait_ready();
        for (int i = 0; i < 4000 && txReady !== 1'b1; i++) @(posedge clk) #1;
    endtask : wait_ready
    // Sends one unit once the transmitter is free, then waits for the echoed reception.
    task automatic xfer(input logic [7:0] d);
        wait_ready();
        txData = d;
        txValid = 1'b1;
        @(posedge clk) #1;
        txValid = 1'b0;
        for (int i = 0; i < 4000 && rxValid !== 1'b1; i++) @(posedge clk) #1;
        check1(rxValid, 1'b1, "no reception");
    endtask : xfer
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // ==========================================================
    // Scenarios
    task automatic test_regs();
        rd(sfm_pkg::SYNC_SERIAL_MODE_ADDR, rdVal);
        check8(rdVal, 8'h00, "sync reset");
        rd(sfm_pkg::ASYNC_FRAME_MODE_ADDR, rdVal);
        check8(rdVal, 8'h00, "async reset");
        wr(sfm_pkg::SYNC_SERIAL_MODE_ADDR, 8'hFF);
        wr(sfm_pkg::ASYNC_FRAME_MODE_ADDR, 8'hFF);
        rd(sfm_pkg::SYNC_SERIAL_MODE_ADDR, rdVal);
        check8(rdVal, 8'hCF, "sync readback");
        rd(sfm_pkg::ASYNC_FRAME_MODE_ADDR, rdVal);
        check8(rdVal, 8'hFC, "async readback");
        rd(16'hFF71, rdVal);
        check8(rdVal, 8'h00, "unmapped read");
        wr(sfm_pkg::SYNC_SERIAL_MODE_ADDR, 8'h00);
        wr(sfm_pkg::ASYNC_FRAME_MODE_ADDR, 8'h00);
    endtask : test_regs
    // Each parity code with two stop bits, then seven-bit characters with odd parity.
    task automatic test_uart();
        logic [7:0] mask;
        for (int p = 0; p < 5; p++) begin
            wr(sfm_pkg::ASYNC_FRAME_MODE_ADDR,
               {2'b11, ((p < 4) ? 2'(p) : sfm_pkg::PARITY_ODD), p < 4, 3'b100});
            check1(txdPin, 1'b1, "line idle");
            mask = (p < 4) ? 8'hFF : 8'h7F;
            xfer(8'hA5 ^ 8'(p));
            check8(rxData & mask, (8'hA5 ^ 8'(p)) & mask, "uart data");
            check1(parityError, 1'b0, "parity flag");
            check1(framingError, 1'b0, "framing flag");
            wait_ready();
        end
        useExtBaud = 1'b1;
        xfer(8'h3C);
        check8(rxData, 8'h3C, "external clock data");
        wait_ready();
        useExtBaud = 1'b0;
    endtask : test_uart
    task automatic test_sync();
        wait_ready();
        wr(sfm_pkg::ASYNC_FRAME_MODE_ADDR, 8'h00);
        wr(sfm_pkg::SYNC_SERIAL_MODE_ADDR, 8'h83);
        @(posedge clk) #1;
        check1(sckOe, 1'b1, "clock drive");
        check1(sckOut, 1'b0, "idle low");
        check1(isPort, 1'b1, "port pin");
        check1(txdOe, 1'b1, "data drive");
        wr(sfm_pkg::SYNC_SERIAL_MODE_ADDR, 8'hC2);
        @(posedge clk) #1;
        check1(sckOut, 1'b1, "idle high");
        check1(isPort, 1'b0, "select pin");
        check1(txReady, 1'b0, "deselected");
        slaveSelectPin = 1'b0;
        xfer(8'h96);
        check8(rxData, 8'h96, "sync data");
        wr(sfm_pkg::SYNC_SERIAL_MODE_ADDR, 8'h00);
        check1(sckOe, 1'b0, "sync off");
    endtask : test_sync
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        {regWrEn, regRdEn, txValid, useExtBaud, regAddr, regWrData, txData} = '0;
        slaveSelectPin = 1'b1;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        test_regs();
        test_uart();
        test_sync();
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule : sfm_serial_mode_tb_top
